// *** design/spc_pkg.sv ***
/*
 * Shared constants, types and the instruction decode table for the
 * serial flash command decoder.
 * Assumes a single 25 MHz system clock and a synchronous reset.
 */
package spc_pkg;

  typedef logic [7:0] spc_byte_t;
  typedef logic [31:0] spc_word_t;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction codes
  localparam spc_byte_t OP_MAKER_SIGNATURE_READ = 8'h90;
  localparam spc_byte_t OP_IDENTIFICATION_READ = 8'h9f;
  localparam spc_byte_t OP_SIGNATURE_READ = 8'hab;
  localparam spc_byte_t OP_STATUS_ONE_READ = 8'h05;
  localparam spc_byte_t OP_STATUS_TWO_READ = 8'h07;
  localparam spc_byte_t OP_CONFIG_READ = 8'h35;
  localparam spc_byte_t OP_REGISTER_WRITE = 8'h01;
  localparam spc_byte_t OP_WRITE_LOCK = 8'h04;
  localparam spc_byte_t OP_WRITE_UNLOCK = 8'h06;
  localparam spc_byte_t OP_FAIL_FLAG_CLEAR = 8'h30;
  localparam spc_byte_t OP_CORRECTION_STATUS_READ = 8'h18;
  localparam spc_byte_t OP_BOOT_REGISTER_READ = 8'h14;
  localparam spc_byte_t OP_BOOT_REGISTER_WRITE = 8'h15;
  localparam spc_byte_t OP_BANK_SELECT_READ = 8'h16;
  localparam spc_byte_t OP_BANK_SELECT_WRITE = 8'h17;
  localparam spc_byte_t OP_BANK_SELECT_ACCESS = 8'hb9;
  localparam spc_byte_t OP_TRAINING_PATTERN_READ = 8'h41;
  localparam spc_byte_t OP_TRAINING_NV_PROGRAM = 8'h43;
  localparam spc_byte_t OP_TRAINING_VOLATILE_WRITE = 8'h4a;
  localparam spc_byte_t OP_NORMAL_READ = 8'h03;
  localparam spc_byte_t OP_NORMAL_READ_WIDE_ADDR = 8'h13;
  localparam spc_byte_t OP_FAST_READ = 8'h0b;
  localparam spc_byte_t OP_FAST_READ_WIDE_ADDR = 8'h0c;
  localparam spc_byte_t OP_DOUBLE_RATE_FAST_READ = 8'h0d;
  localparam spc_byte_t OP_DOUBLE_RATE_FAST_READ_WIDE = 8'h0e;
  localparam spc_byte_t OP_TWO_LINE_OUT_READ = 8'h3b;
  localparam spc_byte_t OP_TWO_LINE_OUT_READ_WIDE = 8'h3c;
  localparam spc_byte_t OP_FOUR_LINE_OUT_READ = 8'h6b;
  localparam spc_byte_t OP_FOUR_LINE_OUT_READ_WIDE = 8'h6c;
  localparam spc_byte_t OP_TWO_LINE_IO_READ = 8'hbb;
  localparam spc_byte_t OP_TWO_LINE_IO_READ_WIDE = 8'hbc;
  localparam spc_byte_t OP_DOUBLE_RATE_TWO_LINE_IO_READ = 8'hbd;

  ////////////////////////////////////////////////////////////////////////////
  // Bank select, training and status register layout and reset values
  localparam int BANK_WIDE_ADDR_BIT = 7;
  localparam int BANK_SEL_W = 2;
  localparam spc_byte_t BANK_RESET = 8'h00;
  localparam spc_byte_t TRAIN_RESET = 8'h00;
  localparam int STATUS_WEL_BIT = 1;

  // Address lengths and last bit of a byte in bits, word lengths in bytes
  localparam logic [5:0] ADDR_BITS_SHORT = 6'h18;
  localparam logic [5:0] ADDR_BITS_LONG = 6'h20;
  localparam logic [5:0] ID_ADDR_BITS = 6'h18;
  localparam logic [5:0] BYTE_LAST_BIT = 6'h07;
  localparam logic [2:0] ID_WORD_BYTES = 3'h4;
  localparam logic [2:0] BOOT_WORD_BYTES = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // Decoded instruction attributes
  typedef struct packed {
    logic known;
    logic [5:0] addr_bits;
    logic [2:0] addr_lanes;
    logic [2:0] data_lanes;
    logic ddr;
    logic array_rd;
    logic wr_data;
    logic rd_data;
  } spc_op_info_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_OPCODE = 3'b001,
    ST_ADDR = 3'b010,
    ST_WRITE = 3'b011,
    ST_OUT = 3'b100,
    ST_STREAM = 3'b101,
    ST_IGNORE = 3'b110
  } spc_state_t;

  // Array read instructions that always carry four address bytes
  function automatic logic spc_is_wide_op(input spc_byte_t op);
    case (op)
      OP_NORMAL_READ_WIDE_ADDR, OP_FAST_READ_WIDE_ADDR, OP_DOUBLE_RATE_FAST_READ_WIDE,
      OP_TWO_LINE_OUT_READ_WIDE, OP_FOUR_LINE_OUT_READ_WIDE, OP_TWO_LINE_IO_READ_WIDE:
        spc_is_wide_op = 1'b1;
      default: spc_is_wide_op = 1'b0;
    endcase
  endfunction

  // Instruction decode table
  function automatic spc_op_info_t spc_decode(input spc_byte_t op, input logic wide);
    spc_op_info_t d;
    logic [5:0] ab;
    d = '0;
    ab = (wide || spc_is_wide_op(op)) ? ADDR_BITS_LONG : ADDR_BITS_SHORT;
    d.known = 1'b1;
    d.addr_lanes = 3'h1;
    d.data_lanes = 3'h1;
    case (op)
      OP_MAKER_SIGNATURE_READ, OP_SIGNATURE_READ: begin
        d.addr_bits = ID_ADDR_BITS;
        d.rd_data = 1'b1;
      end
      OP_IDENTIFICATION_READ: d.rd_data = 1'b1;
      OP_STATUS_ONE_READ, OP_STATUS_TWO_READ, OP_CONFIG_READ: d.rd_data = 1'b1;
      OP_REGISTER_WRITE: d.wr_data = 1'b1;
      OP_WRITE_LOCK, OP_WRITE_UNLOCK, OP_FAIL_FLAG_CLEAR: d.rd_data = 1'b0;
      OP_CORRECTION_STATUS_READ: begin
        d.addr_bits = ADDR_BITS_LONG;
        d.rd_data = 1'b1;
      end
      OP_BOOT_REGISTER_READ: d.rd_data = 1'b1;
      OP_BOOT_REGISTER_WRITE: d.wr_data = 1'b1;
      OP_BANK_SELECT_READ: d.rd_data = 1'b1;
      OP_BANK_SELECT_WRITE, OP_BANK_SELECT_ACCESS: d.wr_data = 1'b1;
      OP_TRAINING_PATTERN_READ: d.rd_data = 1'b1;
      OP_TRAINING_NV_PROGRAM, OP_TRAINING_VOLATILE_WRITE: d.wr_data = 1'b1;
      OP_NORMAL_READ, OP_NORMAL_READ_WIDE_ADDR, OP_FAST_READ, OP_FAST_READ_WIDE_ADDR: begin
        d.addr_bits = ab;
        d.array_rd = 1'b1;
      end
      OP_DOUBLE_RATE_FAST_READ, OP_DOUBLE_RATE_FAST_READ_WIDE: begin
        d.addr_bits = ab;
        d.ddr = 1'b1;
        d.array_rd = 1'b1;
      end
      OP_TWO_LINE_OUT_READ, OP_TWO_LINE_OUT_READ_WIDE: begin
        d.addr_bits = ab;
        d.data_lanes = 3'h2;
        d.array_rd = 1'b1;
      end
      OP_FOUR_LINE_OUT_READ, OP_FOUR_LINE_OUT_READ_WIDE: begin
        d.addr_bits = ab;
        d.data_lanes = 3'h4;
        d.array_rd = 1'b1;
      end
      OP_TWO_LINE_IO_READ, OP_TWO_LINE_IO_READ_WIDE, OP_DOUBLE_RATE_TWO_LINE_IO_READ: begin
        d.addr_bits = ab;
        d.addr_lanes = 3'h2;
        d.data_lanes = 3'h2;
        d.ddr = (op == OP_DOUBLE_RATE_TWO_LINE_IO_READ);
        d.array_rd = 1'b1;
      end
      default: d = '0;
    endcase
    spc_decode = d;
  endfunction

endpackage

// *** design/spc_pin_if.sv ***
/*
 * Synchronised serial pin view passed from the pin synchroniser to the
 * command decoder core.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ns
interface spc_pin_if;
  logic cs_n;
  logic sck_rise;
  logic sck_fall;
  logic [3:0] io;

  modport sync (output cs_n, output sck_rise, output sck_fall, output io);
  modport core (input cs_n, input sck_rise, input sck_fall, input io);
endinterface

// *** design/spc_pin_sync.sv ***
/*
 * Two-stage synchroniser for chip select, serial clock and data lines,
 * with serial clock edge detection.
 * Assumes pins are asynchronous to CLOCK and the serial clock is slow
 * enough to be seen for several system clocks per phase.
 */
`timescale 1ns/1ns
module spc_pin_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic cs_n_pin,
  input wire logic sck_pin,
  input wire logic [3:0] io_pin,
  spc_pin_if.sync pins
);
  import spc_pkg::*;

  typedef struct packed {
    logic [5:0] ff1;
    logic [5:0] ff2;
    logic sck_d;
  } spc_sync_t;

  spc_sync_t r_reg;
  spc_sync_t r_next;

  ////////////////////////////////////////////////////////////////////////////
  // Stage one feeds stage two only; edges come from stage two
  always_comb begin
    r_next = r_reg;
    r_next.ff1 = {cs_n_pin, sck_pin, io_pin};
    r_next.ff2 = r_reg.ff1;
    r_next.sck_d = r_reg.ff2[4];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r_reg <= '{ff1: 6'h20, ff2: 6'h20, sck_d: 1'b0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign pins.cs_n = r_reg.ff2[5];
  assign pins.sck_rise = r_reg.ff2[4] & ~r_reg.sck_d;
  assign pins.sck_fall = ~r_reg.ff2[4] & r_reg.sck_d;
  assign pins.io = r_reg.ff2[3:0];

endmodule

// *** design/spc_cmd_decoder.sv ***
/*
 * Serial flash command decoder: instruction decode, register access,
 * bank select and array read address capture.
 * Assumes an SPI host in mode 0 or 3 with a serial clock well below a
 * quarter of CLOCK; the array itself lies outside and starts on READ_START.
 */
// Contract
// - Banks 00 to 11 map 16 MB ranges
// - 90 maker signature, AB electronic signature
// - 9F returns identification then interface data; code sends 00 after the four ID bytes
// - Status, config, write enable, fail clear commands
// - 18 reads correction status, four-byte address
// - 14 reads, 15 writes boot register
// - 16, 17, B9 reach bank select
// - 41, 43, 4A handle training pattern
// - 03 and 13 normal array read
// - 0B and 0C fast array read
// - 0D and 0E double rate fast read
// - 3B and 3C two-line output read
// - 6B and 6C four-line output read
// - BB and BC two-line address and data
// - BD double rate two-line read
// - Wide bit forces four address bytes
// - Short address takes bank high byte
`timescale 1ns/1ns
module spc_cmd_decoder #(
  parameter spc_pkg::spc_byte_t MAKER_ID = 8'h5a, // Arbitrary value
  parameter spc_pkg::spc_byte_t DEVICE_ID = 8'h3c, // Arbitrary value
  parameter spc_pkg::spc_byte_t SIGNATURE = 8'h21, // Arbitrary value
  parameter spc_pkg::spc_word_t ID_WORD = 32'h5a_02_19_4d // Arbitrary value
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic CS_N,
  input wire logic SCK,
  input wire logic [3:0] IO_IN,
  output logic [3:0] IO_OUT,
  output logic [3:0] IO_OE,
  input wire spc_pkg::spc_byte_t STATUS_ONE,
  input wire spc_pkg::spc_byte_t STATUS_TWO,
  input wire spc_pkg::spc_byte_t CONFIG,
  input wire spc_pkg::spc_byte_t ECC_STATUS,
  input wire spc_pkg::spc_word_t BOOT_REG,
  output logic WRITE_ENABLED,
  output logic FAIL_CLEAR,
  output spc_pkg::spc_byte_t BANK_SELECT,
  output spc_pkg::spc_byte_t TRAINING,
  output logic READ_START,
  output spc_pkg::spc_word_t READ_ADDR,
  output spc_pkg::spc_byte_t READ_OPCODE,
  output logic [2:0] READ_LANES,
  output logic READ_DOUBLE_RATE,
  output logic WR_STROBE,
  output spc_pkg::spc_byte_t WR_DATA,
  output spc_pkg::spc_byte_t WR_OPCODE,
  output logic [2:0] WR_INDEX
);
  import spc_pkg::*;

  typedef struct packed {
    spc_state_t state;
    logic [5:0] cnt;
    spc_byte_t opcode;
    spc_op_info_t info;
    spc_word_t sh;
    spc_byte_t outb;
    logic [2:0] oidx;
    logic so;
    logic oe;
    spc_byte_t bank;
    spc_byte_t train;
    logic wel;
    logic fail_clr;
    logic rd_start;
    spc_word_t rd_addr;
    logic wr_pulse;
    spc_byte_t wr_data;
    logic [2:0] wr_idx;
  } spc_core_t;

  spc_core_t r_reg;
  spc_core_t r_next;
  spc_pin_if pins ();
  spc_op_info_t dec;
  spc_byte_t op_in;
  spc_word_t addr_in;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation
  spc_pin_sync u_sync (
    .clk(CLOCK),
    .rst(RST),
    .cs_n_pin(CS_N),
    .sck_pin(SCK),
    .io_pin(IO_IN),
    .pins(pins.sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Response byte for a register read, by byte index
  function automatic spc_byte_t resp_byte(input spc_byte_t op, input logic [2:0] idx,
                                          input spc_core_t r);
    spc_byte_t b;
    b = 8'h00;
    case (op)
      OP_STATUS_ONE_READ: begin
        b = STATUS_ONE;
        b[STATUS_WEL_BIT] = r.wel;
      end
      OP_STATUS_TWO_READ: b = STATUS_TWO;
      OP_CONFIG_READ: b = CONFIG;
      OP_CORRECTION_STATUS_READ: b = ECC_STATUS;
      OP_BOOT_REGISTER_READ: b = BOOT_REG[8*idx[1:0] +: 8];
      OP_BANK_SELECT_READ: b = r.bank;
      OP_TRAINING_PATTERN_READ: b = r.train;
      OP_MAKER_SIGNATURE_READ: b = idx[0] ? DEVICE_ID : MAKER_ID;
      OP_SIGNATURE_READ: b = SIGNATURE;
      OP_IDENTIFICATION_READ: begin
        if (idx < ID_WORD_BYTES) begin
          b = ID_WORD[8*(3 - idx[1:0]) +: 8];
        end
      end
      default: b = 8'h00;
    endcase
    resp_byte = b;
  endfunction

  // Next shift register contents for the lane count
  function automatic spc_word_t shift_in(input spc_word_t sh, input logic [2:0] lanes,
                                         input logic [3:0] io);
    case (lanes)
      3'h2: shift_in = {sh[29:0], io[1:0]};
      3'h4: shift_in = {sh[27:0], io};
      default: shift_in = {sh[30:0], io[0]};
    endcase
  endfunction

  assign op_in = {r_reg.sh[6:0], pins.io[0]};
  assign dec = spc_decode(op_in, r_reg.bank[BANK_WIDE_ADDR_BIT]);
  assign addr_in = shift_in(r_reg.sh, r_reg.info.addr_lanes, pins.io);

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencer
  always_comb begin
    r_next = r_reg;
    r_next.fail_clr = 1'b0;
    r_next.rd_start = 1'b0;
    r_next.wr_pulse = 1'b0;
    if (pins.cs_n) begin
      r_next.state = ST_IDLE;
      r_next.cnt = 6'h00;
      r_next.oe = 1'b0;
      r_next.so = 1'b0;
    end else begin
      case (r_reg.state)
        ST_IDLE, ST_OPCODE: begin
          r_next.state = ST_OPCODE;
          if (pins.sck_rise) begin
            r_next.sh = {r_reg.sh[30:0], pins.io[0]};
            r_next.cnt = r_reg.cnt + 6'h01;
            if (r_reg.cnt == BYTE_LAST_BIT) begin
              r_next.opcode = op_in;
              r_next.info = dec;
              r_next.cnt = 6'h00;
              r_next.oidx = 3'h0;
              r_next.outb = resp_byte(op_in, 3'h0, r_reg);
              if (!dec.known) begin
                r_next.state = ST_IGNORE;
              end else if (dec.addr_bits != 6'h00) begin
                r_next.state = ST_ADDR;
              end else if (dec.wr_data) begin
                r_next.state = ST_WRITE;
              end else if (dec.rd_data) begin
                r_next.state = ST_OUT;
              end else begin
                r_next.state = ST_IGNORE;
                if (op_in == OP_WRITE_UNLOCK) begin
                  r_next.wel = 1'b1;
                end
                if (op_in == OP_WRITE_LOCK) begin
                  r_next.wel = 1'b0;
                end
                r_next.fail_clr = (op_in == OP_FAIL_FLAG_CLEAR);
              end
            end
          end
        end
        ST_ADDR: begin
          if (pins.sck_rise ||
              (pins.sck_fall && r_reg.info.ddr && r_reg.cnt != 6'h00)) begin
            r_next.sh = addr_in;
            r_next.cnt = r_reg.cnt + {3'h0, r_reg.info.addr_lanes};
            if (r_next.cnt >= r_reg.info.addr_bits) begin
              r_next.cnt = 6'h00;
              if (r_reg.info.addr_bits == ADDR_BITS_SHORT) begin
                r_next.rd_addr = {{(8 - BANK_SEL_W){1'b0}}, r_reg.bank[BANK_SEL_W-1:0],
                                  addr_in[23:0]};
              end else begin
                r_next.rd_addr = addr_in;
              end
              if (r_reg.info.array_rd) begin
                r_next.rd_start = 1'b1;
                r_next.state = ST_STREAM;
              end else begin
                r_next.state = ST_OUT;
              end
            end
          end
        end
        ST_WRITE: begin
          if (pins.sck_rise) begin
            r_next.sh = {r_reg.sh[30:0], pins.io[0]};
            r_next.cnt = r_reg.cnt + 6'h01;
            if (r_reg.cnt == BYTE_LAST_BIT) begin
              r_next.cnt = 6'h00;
              r_next.wr_pulse = 1'b1;
              r_next.wr_data = op_in;
              r_next.wr_idx = r_reg.oidx;
              r_next.oidx = r_reg.oidx + 3'h1;
              if (r_reg.oidx == 3'h0 && (r_reg.opcode == OP_BANK_SELECT_WRITE ||
                                         r_reg.opcode == OP_BANK_SELECT_ACCESS)) begin
                r_next.bank = op_in;
              end
              if (r_reg.oidx == 3'h0 && r_reg.opcode == OP_TRAINING_VOLATILE_WRITE) begin
                r_next.train = op_in;
              end
            end
          end
        end
        ST_OUT: begin
          r_next.oe = 1'b1;
          if (pins.sck_fall) begin
            r_next.so = r_reg.outb[7];
            r_next.outb = {r_reg.outb[6:0], 1'b0};
            r_next.cnt = r_reg.cnt + 6'h01;
            if (r_reg.cnt == BYTE_LAST_BIT) begin
              r_next.cnt = 6'h00;
              r_next.oidx = r_reg.oidx + 3'h1;
              r_next.outb = resp_byte(r_reg.opcode, r_reg.oidx + 3'h1, r_reg);
            end
          end
        end
        ST_STREAM, ST_IGNORE: r_next.state = r_reg.state;
        default: r_next.state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      r_reg <= '0;
      r_reg.state <= ST_IDLE;
      r_reg.bank <= BANK_RESET;
      r_reg.train <= TRAIN_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign IO_OUT = {2'b00, r_reg.so, 1'b0};
  assign IO_OE = {2'b00, r_reg.oe, 1'b0};
  assign WRITE_ENABLED = r_reg.wel;
  assign FAIL_CLEAR = r_reg.fail_clr;
  assign BANK_SELECT = r_reg.bank;
  assign TRAINING = r_reg.train;
  assign READ_START = r_reg.rd_start;
  assign READ_ADDR = r_reg.rd_addr;
  assign READ_OPCODE = r_reg.opcode;
  assign READ_LANES = r_reg.info.data_lanes;
  assign READ_DOUBLE_RATE = r_reg.info.ddr;
  assign WR_STROBE = r_reg.wr_pulse;
  assign WR_DATA = r_reg.wr_data;
  assign WR_OPCODE = r_reg.opcode;
  assign WR_INDEX = r_reg.wr_idx;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_bank_map: assert property (@(posedge CLOCK) disable iff (RST)
    r_reg.rd_start && r_reg.info.addr_bits == ADDR_BITS_SHORT
      |-> r_reg.rd_addr[31:24] == {6'h00, r_reg.bank[1:0]})
    else $error("Short address not mapped through bank select");

  a_wide_addr: assert property (@(posedge CLOCK) disable iff (RST)
    r_reg.rd_start |-> r_reg.info.addr_bits ==
      ((r_reg.bank[BANK_WIDE_ADDR_BIT] || spc_is_wide_op(r_reg.opcode)) ?
        ADDR_BITS_LONG : ADDR_BITS_SHORT))
    else $error("Address length does not follow wide bit");

  a_unknown_ignored: assert property (@(posedge CLOCK) disable iff (RST)
    r_reg.state == ST_OPCODE && !pins.cs_n && pins.sck_rise
      && r_reg.cnt == BYTE_LAST_BIT && !dec.known
      |=> r_reg.state == ST_IGNORE ##1 (!r_reg.oe && !r_reg.wr_pulse && !r_reg.rd_start))
    else $error("Unknown instruction not ignored");

  a_unlock_sets: assert property (@(posedge CLOCK) disable iff (RST)
    r_reg.state == ST_IGNORE && r_reg.opcode == OP_WRITE_UNLOCK |-> r_reg.wel)
    else $error("Write enable not set");

  a_lock_clears: assert property (@(posedge CLOCK) disable iff (RST)
    r_reg.state == ST_IGNORE && r_reg.opcode == OP_WRITE_LOCK |-> !r_reg.wel)
    else $error("Write enable not cleared");

  a_fail_clear: assert property (@(posedge CLOCK) disable iff (RST)
    r_reg.fail_clr |-> r_reg.opcode == OP_FAIL_FLAG_CLEAR && r_reg.state == ST_IGNORE
      ##1 !r_reg.fail_clr)
    else $error("Fail clear pulse wrong");

  a_bank_write: assert property (@(posedge CLOCK) disable iff (RST)
    r_reg.wr_pulse && r_reg.wr_idx == 3'h0 && (r_reg.opcode == OP_BANK_SELECT_WRITE
      || r_reg.opcode == OP_BANK_SELECT_ACCESS) |-> r_reg.bank == r_reg.wr_data)
    else $error("Bank select not written");

  a_ecc_four_byte: assert property (@(posedge CLOCK) disable iff (RST)
    (r_reg.state == ST_ADDR || r_reg.state == ST_OUT)
      && r_reg.opcode == OP_CORRECTION_STATUS_READ |-> r_reg.info.addr_bits == ADDR_BITS_LONG)
    else $error("Correction status read without four-byte address");

  a_two_line_io: assert property (@(posedge CLOCK) disable iff (RST)
    r_reg.rd_start && (r_reg.opcode == OP_TWO_LINE_IO_READ
      || r_reg.opcode == OP_DOUBLE_RATE_TWO_LINE_IO_READ)
      |-> r_reg.info.addr_lanes == 3'h2 && READ_LANES == 3'h2)
    else $error("Two-line read lanes wrong");

  a_deselect_ends: assert property (@(posedge CLOCK) disable iff (RST)
    pins.cs_n |=> r_reg.state == ST_IDLE && !IO_OE[1])
    else $error("Deselect did not end command");

endmodule

// *** sim/spc_host.sv ***
/*
 * SPI host model in mode 0 for the command decoder pins.
 * Assumes callers step it on the falling CLOCK edge.
 */
`timescale 1ns/1ns
module spc_host (
  input wire logic clk,
  input wire logic so,
  output logic cs_n,
  output logic sck,
  output logic [3:0] io
);
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    io = 4'h0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Frame open and close, serial clock idle low between frames
  task automatic start();
    cs_n = 1'b0;
    tick(3);
  endtask
  task automatic stop();
    tick(3);
    cs_n = 1'b1;
    io = ~io;
    tick(8);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // One byte MSB first, 8-clock period under every limit
  task automatic xfer(input logic [7:0] tx, input int ln, input bit ddr,
                      output logic [7:0] rx);
    logic [7:0] s;
    s = tx;
    for (int g = 0; g < 8 / ln; g++) begin
      tick(2);
      io = (ln == 2) ? {2'b0, s[7:6]} : {3'b0, s[7]};
      s = s << ln;
      tick(2);
      sck = ~sck;
      if (!ddr) begin
        tick(4);
        rx = {rx[6:0], so};
        sck = 1'b0;
      end
    end
  endtask
endmodule

// *** sim/spc_cmd_decoder_bench.sv ***
/*
 * Self-checking bench for the command decoder.
 * Assumes the host model spc_host on the serial pins.
 */
`timescale 1ns/1ns
module spc_cmd_decoder_bench;
  import spc_pkg::*;
  localparam spc_byte_t MK = 8'h5a, DV = 8'h3c, SG = 8'h21; // Arbitrary values
  localparam spc_word_t IDW = 32'h5a02194d; // Arbitrary value
  logic clk = 1'b0, rst = 1'b1, cs_n, sck, so, we, fclr, rstart, rdr, wstb;
  logic [3:0] hio, io_out, io_oe;
  logic [2:0] rln, widx;
  spc_byte_t s1, s2, cfg, ecc, bank, trn, wdat, wop, rop, bk;
  spc_word_t boot, raddr;
  int n_fail = 0, num_checks = 0, n_fc = 0, n_rs = 0, n_ws = 0;
  spc_byte_t wops[6] = '{8'h01, 8'h15, 8'h43, 8'h4a, 8'h17, 8'hb9};
  spc_byte_t rops[13] = '{8'h03, 8'h13, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h3b, 8'h3c,
                          8'h6b, 8'h6c, 8'hbb, 8'hbc, 8'hbd};
  always #20 clk = ~clk;
  assign so = io_oe[1] ? io_out[1] : hio[1];
  always @(posedge clk) begin
    n_fc += (fclr === 1'b1);
    n_rs += (rstart === 1'b1);
    n_ws += (wstb === 1'b1);
  end
  spc_host host (.clk(clk), .so(so), .cs_n(cs_n), .sck(sck), .io(hio));
  spc_cmd_decoder #(.MAKER_ID(MK), .DEVICE_ID(DV), .SIGNATURE(SG), .ID_WORD(IDW)) dut (
    .CLOCK(clk), .RST(rst), .CS_N(cs_n), .SCK(sck), .IO_IN({hio[3:2], so, hio[0]}),
    .IO_OUT(io_out), .IO_OE(io_oe), .STATUS_ONE(s1), .STATUS_TWO(s2), .CONFIG(cfg),
    .ECC_STATUS(ecc), .BOOT_REG(boot), .WRITE_ENABLED(we), .FAIL_CLEAR(fclr),
    .BANK_SELECT(bank), .TRAINING(trn), .READ_START(rstart), .READ_ADDR(raddr),
    .READ_OPCODE(rop), .READ_LANES(rln), .READ_DOUBLE_RATE(rdr), .WR_STROBE(wstb),
    .WR_DATA(wdat), .WR_OPCODE(wop), .WR_INDEX(widx));
  ////////////////////////////////////////////////////////////////////////////
  // Expectations and checks
  function automatic logic [2:0] f_lanes(input spc_byte_t op);
    if (op inside {8'h6b, 8'h6c}) return 3'h4;
    return (op inside {8'h3b, 8'h3c, 8'hbb, 8'hbc, 8'hbd}) ? 3'h2 : 3'h1;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Command tasks
  task automatic rd(input spc_byte_t op, input int na, output spc_word_t v);
    spc_byte_t b;
    host.start();
    host.xfer(op, 1, 0, b);
    repeat (na) host.xfer(8'($urandom), 1, 0, b);
    for (int i = 0; i < 4; i++) begin
      host.xfer(8'h00, 1, 0, b);
      v = {v[23:0], b};
    end
    host.stop();
  endtask
  task automatic wr(input spc_byte_t op, input spc_byte_t d);
    spc_byte_t b;
    host.start();
    host.xfer(op, 1, 0, b);
    host.xfer(d, 1, 0, b);
    host.stop();
  endtask
  task automatic rdarr(input spc_byte_t op);
    spc_word_t a;
    spc_byte_t b;
    int nb, n0;
    bit dd;
    a = $urandom;
    dd = op inside {8'h0d, 8'h0e, 8'hbd};
    nb = (bk[7] || op inside {8'h13, 8'h0c, 8'h0e, 8'h3c, 8'h6c, 8'hbc}) ? 4 : 3;
    n0 = n_rs;
    host.start();
    host.xfer(op, 1, 0, b);
    for (int i = nb - 1; i >= 0; i--) begin
      host.xfer(a[8*i +: 8], (op inside {8'hbb, 8'hbc, 8'hbd}) ? 2 : 1, dd, b);
    end
    host.tick(8);
    chk(n_rs - n0, 1);
    chk(raddr, nb == 4 ? a : {6'h0, bk[1:0], a[23:0]});
    chk({rop, 1'b0, rln, 3'h0, rdr}, {op, 1'b0, f_lanes(op), 3'h0, dd});
    host.stop();
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    spc_word_t v;
    spc_byte_t d;
    int n0;
    v = $urandom(32'h68178848);
    {s1, s2, cfg, ecc} = $urandom;
    boot = $urandom;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    host.tick(3);
    chk({bank, trn, 7'h0, we}, 24'h0);
    wr(8'h55, 8'h06);
    chk(we, 1'b0);
    wr(8'h06, 8'($urandom));
    rd(8'h05, 0, v);
    chk(v, {4{s1 | 8'h02}});
    wr(8'h04, 8'hff);
    rd(8'h05, 0, v);
    chk(v, {4{s1 & 8'hfd}});
    n0 = n_fc;
    wr(8'h30, 8'h00);
    chk(n_fc - n0, 1);
    rd(8'h07, 0, v);
    chk(v, {4{s2}});
    rd(8'h35, 0, v);
    chk(v, {4{cfg}});
    rd(8'h18, 4, v);
    chk(v, {4{ecc}});
    rd(8'h14, 0, v);
    chk(v, {boot[7:0], boot[15:8], boot[23:16], boot[31:24]});
    rd(8'h9f, 0, v);
    chk(v, IDW);
    rd(8'h90, 3, v);
    chk(v, {MK, DV, MK, DV});
    rd(8'hab, 3, v);
    chk(v, {4{SG}});
    $display("register reads done");
    foreach (wops[i]) begin
      d = $urandom;
      if (wops[i] inside {8'h17, 8'hb9}) d = d & 8'h03;
      n0 = n_ws;
      wr(wops[i], d);
      chk(n_ws - n0, 1);
      chk({widx, wdat, wop}, {3'h0, d, wops[i]});
      if (wops[i] inside {8'h17, 8'hb9}) chk(bank, d);
      if (wops[i] == 8'h4a) chk(trn, d);
    end
    rd(8'h41, 0, v);
    chk(v, {4{trn}});
    $display("register writes done");
    for (int p = 0; p < 2; p++) begin
      bk = {p[0], 5'h0, 2'($urandom)};
      wr(8'h17, bk);
      rd(8'h16, 0, v);
      chk(v, {4{bk}});
      foreach (rops[i]) rdarr(rops[i]);
    end
    $display("array reads done");
    end_sim();
  end
  initial begin
    #2000000;
    n_fail++;
    end_sim();
  end
endmodule
